// ===== common/psir_pkg.sv
// Purpose: Shared constants and types for the power-state and interrupt-routing link.
// Assumes: Device registers hold 8-bit data behind 7-bit addresses on a four-wire serial link.
// Notes: A frame is 16 bits, MSB first: read flag, 7-bit address, 8-bit data.
// Operation
// - Two states only, changed by software alone.
// - Hold state after power-up.
// - Reset command honoured only in active state.
// - Hold to active within one sample period.
// - Hold state stops clock and sampling.
// - Hold state allows full register writes.
// - Active state: only mode register writable.
// - Active state runs clock and samples continuously.
// - Status register shows two-bit state field.
// - Mode 00 forces hold, 01 forces active.
// - Pins default open-drain active-low, fixed routing.
// - Per-pin drive and polarity at 0x33.
// - Sample plus motion request, FIFO request.
// - Clears via 0x14; 0x31 bit 6 per-bit.
// - Requests swappable or combinable between pins.
// - Combined request pin chosen by 0x31 bit 4.
// - Sample data updates only after a stop.
// - Polling host reads status at sample rate.
// - Global mode: writes to 0x04/0x14 clear all.
// - Per-bit mode: ones clear, bit 5 FIFO.
package psir_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int STATE_FIELD_W = 2;
    localparam int MOTION_COUNT = 5;
    localparam int FIFO_COUNT = 3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR_ALIAS = 7'h04;
    localparam logic [ADDR_W-1:0] ADDR_SAMPLE = 7'h06;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = 7'h14;
    localparam logic [ADDR_W-1:0] ADDR_RANGE = 7'h20;
    localparam logic [ADDR_W-1:0] ADDR_FIFO_FLAGS = 7'h2F;
    localparam logic [ADDR_W-1:0] ADDR_ROUTING = 7'h31;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DRIVE = 7'h33;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam int MODE_RESET_BIT = 6;
    localparam int RT_SWAP_BIT = 0;
    localparam int RT_COMBINE_BIT = 1;
    localparam int RT_COMBINED_PIN_BIT = 4;
    localparam int RT_PER_BIT_CLEAR_BIT = 6;
    localparam int PD_A_PUSH_PULL_BIT = 0;
    localparam int PD_A_ACTIVE_HIGH_BIT = 1;
    localparam int PD_B_PUSH_PULL_BIT = 2;
    localparam int PD_B_ACTIVE_HIGH_BIT = 3;
    localparam int FLAG_FIFO_GROUP_BIT = 5;
    localparam int FLAG_SAMPLE_BIT = 7;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] LAST_ADDR_COUNT = 5'h07;
    localparam logic [4:0] FIRST_DATA_COUNT = 5'h08;
    localparam logic [4:0] LAST_FRAME_COUNT = 5'h0F;
    localparam logic [4:0] FRAME_COUNT = 5'h10;
    localparam int CLOCK_NS = 10;
    localparam int WAKE_LIMIT_NS = 10000;
    localparam int WAKE_LIMIT_CYCLES = WAKE_LIMIT_NS / CLOCK_NS;
    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] HOST_CMD_ADDR = 8'h00;
    localparam logic [APB_ADDR_W-1:0] HOST_STATUS_ADDR = 8'h04;
    localparam int CMD_READ_BIT = 15;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int STATUS_PIN_A_BIT = 9;
    localparam int STATUS_PIN_B_BIT = 10;
    typedef enum logic [1:0] {OP_HOLD = 2'h0, OP_ACTIVE = 2'h1} op_state_e;
    typedef enum logic [1:0] {H_IDLE = 2'h0, H_LOW = 2'h1, H_HIGH = 2'h3, H_TAIL = 2'h2} host_state_e;
endpackage : psir_pkg

// ===== common/psir_link.sv
// Purpose: Serial register link and two interrupt pins between host and device.
// Assumes: Interrupt wires carry a pull-up, so an undriven pin reads high.
// Notes: The pin level is resolved here from each driver's output and enable.
`timescale 1ns/100ps
interface psir_link;
    logic sck;
    logic csn;
    logic mosi;
    logic miso;
    logic irq_a_out;
    logic irq_a_oe;
    logic irq_b_out;
    logic irq_b_oe;
    logic irq_pin_a;
    logic irq_pin_b;

    assign irq_pin_a = irq_a_oe ? irq_a_out : 1'h1;
    assign irq_pin_b = irq_b_oe ? irq_b_out : 1'h1;

    modport device (input sck, input csn, input mosi, output miso,
                    output irq_a_out, output irq_a_oe, output irq_b_out, output irq_b_oe);
    modport host (output sck, output csn, output mosi, input miso, input irq_pin_a, input irq_pin_b);
endinterface : psir_link

// ===== logic/psir_irq_pin.sv
// Purpose: Drives one interrupt pin from a request with selectable drive and polarity.
// Assumes: Controls come from registers on the same clock.
// Notes: Open-drain can only pull low, so a high level releases the pin.
`timescale 1ns/100ps
module psir_irq_pin (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_request,
    input wire logic i_push_pull,
    input wire logic i_active_high,
    output logic o_pin,
    output logic o_pin_oe
);
    typedef struct packed {
        logic pin;
        logic oe;
    } pin_state_s;
    pin_state_s s;
    pin_state_s next_s;
    logic level;

    always_comb begin
        level = i_request ? i_active_high : !i_active_high;
        next_s = s;
        if (i_push_pull) begin
            next_s.pin = level;
            next_s.oe = 1'h1;
        end else begin
            next_s.pin = 1'h0;
            next_s.oe = !level;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_pin = s.pin;
    assign o_pin_oe = s.oe;
endmodule : psir_irq_pin

// ===== logic/psir_device.sv
// Purpose: Device end: operating states, register access, interrupt flags and pin routing.
// Assumes: Event inputs are one-cycle pulses on i_clock; link pins are asynchronous.
// Notes: Link is mode 0 serial, sampled on rising clock edge, MSB first.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module psir_device #(
    parameter int SAMPLE_CYCLES = psir_pkg::WAKE_LIMIT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    psir_link.device link,
    input wire logic [psir_pkg::MOTION_COUNT-1:0] i_motion_events,
    input wire logic [psir_pkg::FIFO_COUNT-1:0] i_fifo_events,
    input wire logic [psir_pkg::DATA_W-1:0] i_sample_value,
    output logic o_clock_run,
    output logic o_sample_pulse
);
    import psir_pkg::*;

    localparam int DIV_W = $clog2(SAMPLE_CYCLES + 1);

    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic csn_s1;
        logic csn_s2;
        logic csn_d;
        logic mosi_s1;
        logic mosi_s2;
        logic [4:0] bit_cnt;
        logic [FRAME_BITS-2:0] rx;
        logic [DATA_W-1:0] tx;
        logic miso;
        op_state_e op;
        logic clock_run;
        logic [DATA_W-1:0] range_cfg;
        logic [DATA_W-1:0] routing;
        logic [DATA_W-1:0] pin_drive;
        logic [DATA_W-1:0] sample_data;
        logic [MOTION_COUNT-1:0] motion_flags;
        logic sample_flag;
        logic [FIFO_COUNT-1:0] fifo_flags;
        logic stop_seen;
        logic [DIV_W-1:0] div;
        logic sample_pulse;
    } dev_state_s;

    dev_state_s s;
    dev_state_s next_s;
    logic rise;
    logic fall;
    logic wr_strobe;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic hold;
    logic soft_reset;
    logic clr_sample;
    logic [MOTION_COUNT-1:0] clr_motion;
    logic [FIFO_COUNT-1:0] clr_fifo;
    logic sample_now;
    logic req_sample_motion;
    logic req_fifo;
    logic to_pin_a;
    logic to_pin_b;

    // Register read view; reserved bits and unmapped addresses read as zero.
    function automatic logic [DATA_W-1:0] read_reg(input dev_state_s st, input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        case (a)
            ADDR_STATUS, ADDR_MODE: begin
                v[STATE_FIELD_W-1:0] = st.op;
            end
            ADDR_RANGE: begin
                v = st.range_cfg;
            end
            ADDR_SAMPLE: begin
                v = st.sample_data;
            end
            ADDR_IRQ_FLAGS: begin
                v[MOTION_COUNT-1:0] = st.motion_flags;
                v[FLAG_FIFO_GROUP_BIT] = |st.fifo_flags;
                v[FLAG_SAMPLE_BIT] = st.sample_flag;
            end
            ADDR_FIFO_FLAGS: begin
                v[FIFO_COUNT-1:0] = st.fifo_flags;
            end
            ADDR_ROUTING: begin
                v = st.routing;
            end
            ADDR_PIN_DRIVE: begin
                v = st.pin_drive;
            end
            default: begin
                v = REG_RESET;
            end
        endcase
        return v;
    endfunction : read_reg

    always_comb begin
        next_s = s;
        next_s.sck_s1 = link.sck;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_d = s.sck_s2;
        next_s.csn_s1 = link.csn;
        next_s.csn_s2 = s.csn_s1;
        next_s.csn_d = s.csn_s2;
        next_s.mosi_s1 = link.mosi;
        next_s.mosi_s2 = s.mosi_s1;
        next_s.sample_pulse = 1'h0;
        hold = (s.op == OP_HOLD);
        rise = !s.csn_s2 && s.sck_s2 && !s.sck_d;
        fall = !s.csn_s2 && !s.sck_s2 && s.sck_d && (s.bit_cnt >= FIRST_DATA_COUNT);
        rd_addr = {s.rx[ADDR_W-2:0], s.mosi_s2};
        wr_addr = s.rx[DATA_W-1 +: ADDR_W];
        wr_data = {s.rx[DATA_W-2:0], s.mosi_s2};
        wr_strobe = rise && (s.bit_cnt == LAST_FRAME_COUNT) && !s.rx[FRAME_BITS-2];
        soft_reset = 1'h0;
        clr_sample = 1'h0;
        clr_motion = '0;
        clr_fifo = '0;

        // Serial frame: shift in, answer reads from the data byte onward.
        if (s.csn_s2) begin
            next_s.bit_cnt = '0;
        end else if (rise && (s.bit_cnt != FRAME_COUNT)) begin
            next_s.rx = {s.rx[FRAME_BITS-3:0], s.mosi_s2};
            next_s.bit_cnt = s.bit_cnt + 5'h01;
            if ((s.bit_cnt == LAST_ADDR_COUNT) && s.rx[ADDR_W-1]) begin
                next_s.tx = read_reg(s, rd_addr);
            end
        end
        if (fall) begin
            next_s.miso = s.tx[DATA_W-1];
            next_s.tx = {s.tx[DATA_W-2:0], 1'h0};
        end

        // Register writes: full access in hold, mode register only when active.
        if (wr_strobe) begin
            case (wr_addr)
                ADDR_MODE: begin
                    if (!hold && wr_data[MODE_RESET_BIT]) begin
                        soft_reset = 1'h1;
                    end else if (wr_data[STATE_FIELD_W-1:0] == OP_HOLD) begin
                        next_s.op = OP_HOLD;
                    end else if (wr_data[STATE_FIELD_W-1:0] == OP_ACTIVE) begin
                        next_s.op = OP_ACTIVE;
                    end
                end
                ADDR_RANGE: begin
                    if (hold) begin
                        next_s.range_cfg = wr_data;
                    end
                end
                ADDR_ROUTING: begin
                    if (hold) begin
                        next_s.routing = wr_data;
                    end
                end
                ADDR_PIN_DRIVE: begin
                    if (hold) begin
                        next_s.pin_drive = wr_data;
                    end
                end
                default: begin
                end
            endcase
            // Clearing is an address effect and is allowed in either state.
            if (!s.routing[RT_PER_BIT_CLEAR_BIT]) begin
                if ((wr_addr == ADDR_IRQ_FLAGS) || (wr_addr == ADDR_CLEAR_ALIAS)) begin
                    clr_sample = 1'h1;
                    clr_motion = '1;
                    clr_fifo = '1;
                end
            end else if (wr_addr == ADDR_IRQ_FLAGS) begin
                clr_sample = wr_data[FLAG_SAMPLE_BIT];
                clr_motion = wr_data[MOTION_COUNT-1:0];
                clr_fifo = {FIFO_COUNT{wr_data[FLAG_FIFO_GROUP_BIT]}};
            end
        end

        // Sample timer runs only while active; held at zero otherwise.
        sample_now = 1'h0;
        if (hold) begin
            next_s.div = '0;
        end else if (s.div == DIV_W'(SAMPLE_CYCLES - 1)) begin
            next_s.div = '0;
            sample_now = 1'h1;
        end else begin
            next_s.div = s.div + DIV_W'(1);
        end
        if (sample_now) begin
            next_s.sample_pulse = 1'h1;
            if (s.stop_seen) begin
                next_s.sample_data = i_sample_value;
                next_s.stop_seen = 1'h0;
            end
        end
        // A frame end in the same cycle still counts for the next sample.
        if (s.csn_s2 && !s.csn_d) begin
            next_s.stop_seen = 1'h1;
        end

        // New events win over a clear in the same cycle.
        next_s.sample_flag = (s.sample_flag && !clr_sample) || sample_now;
        next_s.motion_flags = (s.motion_flags & ~clr_motion) | (hold ? '0 : i_motion_events);
        next_s.fifo_flags = (s.fifo_flags & ~clr_fifo) | (hold ? '0 : i_fifo_events);

        if (soft_reset) begin
            next_s.op = OP_HOLD;
            next_s.range_cfg = REG_RESET;
            next_s.routing = REG_RESET;
            next_s.pin_drive = REG_RESET;
            next_s.sample_data = REG_RESET;
            next_s.sample_flag = 1'h0;
            next_s.motion_flags = '0;
            next_s.fifo_flags = '0;
            next_s.div = '0;
        end
        next_s.clock_run = (next_s.op == OP_ACTIVE);

        // Request grouping and pin routing.
        req_sample_motion = s.sample_flag || (|s.motion_flags);
        req_fifo = |s.fifo_flags;
        if (s.routing[RT_COMBINE_BIT]) begin
            to_pin_a = !s.routing[RT_COMBINED_PIN_BIT] && (req_sample_motion || req_fifo);
            to_pin_b = s.routing[RT_COMBINED_PIN_BIT] && (req_sample_motion || req_fifo);
        end else if (s.routing[RT_SWAP_BIT]) begin
            to_pin_a = req_fifo;
            to_pin_b = req_sample_motion;
        end else begin
            to_pin_a = req_sample_motion;
            to_pin_b = req_fifo;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            s <= '0;
            s.sck_s1 <= 1'h0;
            s.csn_s1 <= 1'h1;
            s.csn_s2 <= 1'h1;
            s.csn_d <= 1'h1;
            s.op <= OP_HOLD;
        end else begin
            s <= next_s;
        end
    end

    psir_irq_pin pin_a (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_request(to_pin_a),
        .i_push_pull(s.pin_drive[PD_A_PUSH_PULL_BIT]),
        .i_active_high(s.pin_drive[PD_A_ACTIVE_HIGH_BIT]),
        .o_pin(link.irq_a_out),
        .o_pin_oe(link.irq_a_oe)
    );

    psir_irq_pin pin_b (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_request(to_pin_b),
        .i_push_pull(s.pin_drive[PD_B_PUSH_PULL_BIT]),
        .i_active_high(s.pin_drive[PD_B_ACTIVE_HIGH_BIT]),
        .o_pin(link.irq_b_out),
        .o_pin_oe(link.irq_b_oe)
    );

    assign link.miso = s.miso;
    assign o_clock_run = s.clock_run;
    assign o_sample_pulse = s.sample_pulse;
endmodule : psir_device

// ===== logic/psir_host.sv
// Purpose: Host end: APB-controlled serial master that reads and writes device registers.
// Assumes: HALF_CYCLES of at least 6 so read data settles across both synchronisers.
// Notes: Command writes while busy are dropped; software polls the busy bit.
`timescale 1ns/100ps
module psir_host #(
    parameter int HALF_CYCLES = 8
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [psir_pkg::APB_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    psir_link.host link
);
    import psir_pkg::*;

    localparam int CNT_W = $clog2(2 * HALF_CYCLES);

    typedef struct packed {
        host_state_e state;
        logic [CNT_W-1:0] cnt;
        logic [4:0] bit_cnt;
        logic [FRAME_BITS-1:0] tx;
        logic [DATA_W-1:0] rx;
        logic busy;
        logic sck;
        logic csn;
        logic mosi;
        logic miso_s1;
        logic miso_s2;
        logic pa_s1;
        logic pa_s2;
        logic pb_s1;
        logic pb_s2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } host_state_s;

    host_state_s s;
    host_state_s next_s;
    logic [31:0] status;
    logic half_done;

    always_comb begin
        next_s = s;
        next_s.miso_s1 = link.miso;
        next_s.miso_s2 = s.miso_s1;
        next_s.pa_s1 = link.irq_pin_a;
        next_s.pa_s2 = s.pa_s1;
        next_s.pb_s1 = link.irq_pin_b;
        next_s.pb_s2 = s.pb_s1;
        next_s.pready = 1'h0;
        next_s.pslverr = 1'h0;
        status = 32'h0;
        status[DATA_W-1:0] = s.rx;
        status[STATUS_BUSY_BIT] = s.busy;
        status[STATUS_PIN_A_BIT] = s.pa_s2;
        status[STATUS_PIN_B_BIT] = s.pb_s2;
        half_done = (s.cnt == CNT_W'(HALF_CYCLES - 1));

        // APB setup cycle prepares a zero-wait answer for the access cycle.
        if (i_psel && !i_penable) begin
            next_s.pready = 1'h1;
            next_s.prdata = (i_paddr == HOST_STATUS_ADDR) ? status : 32'h0;
            next_s.pslverr = (i_paddr != HOST_STATUS_ADDR) && (i_paddr != HOST_CMD_ADDR);
        end
        if (i_psel && i_penable && s.pready && i_pwrite && (i_paddr == HOST_CMD_ADDR) && !s.busy) begin
            next_s.busy = 1'h1;
            next_s.state = H_LOW;
            next_s.cnt = '0;
            next_s.bit_cnt = '0;
            next_s.tx = i_pwdata[FRAME_BITS-1:0];
            next_s.csn = 1'h0;
            next_s.mosi = i_pwdata[CMD_READ_BIT];
        end

        case (s.state)
            H_IDLE: begin
            end
            H_LOW: begin
                next_s.cnt = half_done ? '0 : s.cnt + CNT_W'(1);
                if (half_done) begin
                    next_s.sck = 1'h1;
                    next_s.rx = {s.rx[DATA_W-2:0], s.miso_s2};
                    next_s.state = H_HIGH;
                end
            end
            H_HIGH: begin
                next_s.cnt = half_done ? '0 : s.cnt + CNT_W'(1);
                if (half_done) begin
                    next_s.sck = 1'h0;
                    next_s.bit_cnt = s.bit_cnt + 5'h01;
                    next_s.tx = {s.tx[FRAME_BITS-2:0], 1'h0};
                    next_s.mosi = s.tx[FRAME_BITS-2];
                    next_s.state = (s.bit_cnt == LAST_FRAME_COUNT) ? H_TAIL : H_LOW;
                end
            end
            H_TAIL: begin
                // Frame end is the stop that lets the device refresh sample data.
                next_s.cnt = s.cnt + CNT_W'(1);
                if (half_done) begin
                    next_s.csn = 1'h1;
                end
                if (s.cnt == CNT_W'(2 * HALF_CYCLES - 1)) begin
                    next_s.cnt = '0;
                    next_s.busy = 1'h0;
                    next_s.state = H_IDLE;
                end
            end
            default: begin
                next_s.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            s <= '0;
            s.state <= H_IDLE;
            s.csn <= 1'h1;
        end else begin
            s <= next_s;
        end
    end

    assign link.sck = s.sck;
    assign link.csn = s.csn;
    assign link.mosi = s.mosi;
    assign o_prdata = s.prdata;
    assign o_pready = s.pready;
    assign o_pslverr = s.pslverr;
endmodule : psir_host

// ===== bench/psir_link_properties.sv
// Purpose: Link timing and reset properties.
// Assumes: Host half period of 8 clock cycles.
// Notes: Watches only the link wires.
`timescale 1ns/100ps
module psir_link_properties (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_sck,
    input wire logic i_csn,
    input wire logic i_mosi,
    input wire logic i_irq_a_oe,
    input wire logic i_irq_b_oe
);
    logic [4:0] rises;
    logic sck_q;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    always_ff @(posedge i_clock) begin
        sck_q <= i_sck;
        if (i_srst || i_csn) begin
            rises <= 5'h00;
        end else if (i_sck && !sck_q) begin
            rises <= rises + 5'h01;
        end
    end
    sequence sck_quiet;
        !i_sck [*8];
    endsequence
    sequence frame_close;
        ##[256:272] $rose(i_csn);
    endsequence
    idle_sck_a: assert property (i_csn |-> !i_sck)
        else $error("sck moved outside a frame");
    lead_gap_a: assert property ($fell(i_csn) |-> sck_quiet)
        else $error("sck rose too soon after select");
    high_phase_a: assert property ($rose(i_sck) |-> i_sck [*8])
        else $error("sck high phase too short");
    bit_count_a: assert property ($rose(i_csn) |-> rises == 5'h10)
        else $error("frame did not hold sixteen bits");
    stop_gap_a: assert property ($rose(i_csn) |-> i_csn [*8])
        else $error("stop gap too short");
    frame_len_a: assert property ($fell(i_csn) |-> frame_close)
        else $error("frame length out of range");
    mosi_hold_a: assert property (i_sck && $past(i_sck) |-> $stable(i_mosi))
        else $error("mosi changed while sck high");
    reset_idle_a: assert property (disable iff (1'b0) i_srst |=> i_csn && !i_sck && !i_irq_a_oe && !i_irq_b_oe)
        else $error("link not idle after reset");
endmodule : psir_link_properties

// ===== bench/tb_top.sv
// Purpose: Drives both link ends through APB and device events.
// Assumes: Host half period 8 cycles, sample tick every 1000 cycles.
// Notes: Scenarios run in order and share device state.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import psir_pkg::*;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic perr;
    logic [4:0] motion = 5'h00;
    logic [2:0] fifo = 3'h0;
    logic [7:0] sval = 8'h00;
    logic clock_run;
    logic spulse;
    logic [7:0] q;
    int miscompares = 0;
    int checks_done = 0;
    psir_link link ();
    psir_host psir_host_i (.i_clock(clock), .i_srst(srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .link(link));
    psir_device psir_device_i (.i_clock(clock), .i_srst(srst), .link(link), .i_motion_events(motion),
        .i_fifo_events(fifo), .i_sample_value(sval), .o_clock_run(clock_run), .o_sample_pulse(spulse));
    psir_link_properties psir_link_properties_i (.i_clock(clock), .i_srst(srst), .i_sck(link.sck),
        .i_csn(link.csn), .i_mosi(link.mosi), .i_irq_a_oe(link.irq_a_oe), .i_irq_b_oe(link.irq_b_oe));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic end_of_test();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, n, lim);
            end_of_test();
        end
    endtask : bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 20);
        bound(n, 20);
        r = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // One device frame, then status polls until the host is idle again.
    task automatic dev(input logic rd, input logic [6:0] a, input logic [7:0] d);
        logic [31:0] r;
        int n;
        apb(1'h1, HOST_CMD_ADDR, {16'h0000, rd, a, d}, r);
        n = 0;
        do begin
            apb(1'h0, HOST_STATUS_ADDR, 32'h0, r);
            n++;
        end while (r[STATUS_BUSY_BIT] !== 1'h0 && n < 200);
        bound(n, 200);
        q = r[7:0];
    endtask : dev
    task automatic tick();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (spulse !== 1'h1 && n < 1200);
        bound(n, 1200);
        repeat (4) @(posedge clock);
    endtask : tick
    task automatic pulse(input logic [4:0] m, input logic [2:0] f);
        @(posedge clock);
        motion <= m;
        fifo <= f;
        @(posedge clock);
        motion <= 5'h00;
        fifo <= 3'h0;
    endtask : pulse
    task automatic states_check();
        logic [31:0] r;
        apb(1'h0, 8'h08, 32'h0, r);
        `CHK(perr, 1'h1);
        dev(1'h1, ADDR_STATUS, 8'h00);
        `CHK(q, 8'h00);
        `CHK(clock_run, 1'h0);
        dev(1'h0, ADDR_RANGE, 8'h5A);
        dev(1'h0, ADDR_MODE, 8'h40);
        dev(1'h1, ADDR_RANGE, 8'h00);
        `CHK(q, 8'h5A);
        dev(1'h0, ADDR_MODE, 8'h01);
        `CHK(clock_run, 1'h1);
        dev(1'h0, ADDR_RANGE, 8'hA5);
        dev(1'h0, ADDR_MODE, 8'h02);
        dev(1'h1, ADDR_RANGE, 8'h00);
        `CHK(q, 8'h5A);
        dev(1'h1, ADDR_STATUS, 8'h00);
        `CHK(q, 8'h01);
        dev(1'h0, ADDR_MODE, 8'h40);
        dev(1'h1, ADDR_RANGE, 8'h00);
        `CHK(q, 8'h00);
        `CHK(clock_run, 1'h0);
    endtask : states_check
    task automatic irq_check();
        dev(1'h0, ADDR_MODE, 8'h01);
        tick();
        pulse(5'h03, 3'h1);
        dev(1'h1, ADDR_IRQ_FLAGS, 8'h00);
        `CHK(q, 8'hA3);
        `CHK({link.irq_pin_a, link.irq_pin_b}, 2'h0);
        dev(1'h1, ADDR_FIFO_FLAGS, 8'h00);
        dev(1'h1, ADDR_FIFO_FLAGS, 8'h00);
        `CHK(q, 8'h01);
        dev(1'h0, ADDR_CLEAR_ALIAS, 8'h00);
        dev(1'h1, ADDR_FIFO_FLAGS, 8'h00);
        `CHK(q, 8'h00);
        dev(1'h1, ADDR_IRQ_FLAGS, 8'h00);
        `CHK(q & 8'h7F, 8'h00);
        dev(1'h0, ADDR_MODE, 8'h00);
        dev(1'h0, ADDR_ROUTING, 8'h40);
        dev(1'h0, ADDR_MODE, 8'h01);
        pulse(5'h03, 3'h4);
        dev(1'h0, ADDR_CLEAR_ALIAS, 8'hFF);
        dev(1'h0, ADDR_IRQ_FLAGS, 8'h01);
        dev(1'h1, ADDR_IRQ_FLAGS, 8'h00);
        `CHK(q & 8'h7F, 8'h22);
        dev(1'h0, ADDR_IRQ_FLAGS, 8'h20);
        dev(1'h1, ADDR_FIFO_FLAGS, 8'h00);
        `CHK(q, 8'h00);
    endtask : irq_check
    // Rows hold routing, pin drive, then expected pin a, pin b and pin a enable.
    task automatic route_check();
        logic [18:0] rows [6];
        logic [31:0] r;
        rows = '{19'h00003, 19'h00804, 19'h01003, 19'h09004, 19'h0007D, 19'h00016};
        foreach (rows[i]) begin
            dev(1'h0, ADDR_MODE, 8'h00);
            dev(1'h0, ADDR_ROUTING, rows[i][18:11]);
            dev(1'h0, ADDR_PIN_DRIVE, rows[i][10:3]);
            dev(1'h0, ADDR_CLEAR_ALIAS, 8'h00);
            dev(1'h0, ADDR_MODE, 8'h01);
            tick();
            `CHK({link.irq_pin_a, link.irq_pin_b, link.irq_a_oe}, rows[i][2:0]);
            apb(1'h0, HOST_STATUS_ADDR, 32'h0, r);
            `CHK(r[10:9], {rows[i][1], rows[i][2]});
        end
    endtask : route_check
    task automatic stop_check();
        // New data goes out before the frame, so a tick that lands just after its end captures it as well.
        sval <= 8'h3C;
        dev(1'h1, ADDR_SAMPLE, 8'h00);
        tick();
        dev(1'h1, ADDR_SAMPLE, 8'h00);
        `CHK(q, 8'h3C);
        tick();
        sval <= 8'hC3;
        tick();
        dev(1'h1, ADDR_SAMPLE, 8'h00);
        `CHK(q, 8'h3C);
        tick();
        dev(1'h1, ADDR_SAMPLE, 8'h00);
        `CHK(q, 8'hC3);
    endtask : stop_check
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'h0;
        states_check();
        irq_check();
        route_check();
        stop_check();
        end_of_test();
    end
endmodule : tb_top
